//--- core/acc_adc_cal.sv
// adc calibration and correction datapath with its axi4-lite register slave
// Overview of operation
// R01: each of sixteen cells has own gain
// R02: shared cell offset, shared divider offset
// R03: unwritten gain falls back to trim/default
// R04: written gain replaces trim and default
// R05: subtract trim, apply gain, subtract offset
// R06: full access reads unwritten gain as trim
// R07: config mode reads zero or written gain
// R08: outside config mode read gain in use
// R09: defaults 12120 cells, 4040 adc input
// R10: cell result gain*count/65536 minus cell offset
// R11: divider results minus divider offset
// R12: adc input result has no offset
// R13: cells in mV, dividers in user units
// R14: host enters config mode, applies voltage first
// R15: overvoltage search stores and returns coefficient
// R16: undervoltage search stores and returns coefficient
// R17: nonzero override replaces factory threshold trim
// R18: current is (raw - offset/samples) times gain
// R19: capacity gain is gain times 298261.6178
// R20: current gains are single precision floats
// R21: host sets gain from sense resistance
// R22: saturate results instead of wrapping
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module acc_adc_cal (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    // axi4-lite write
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [8:0]            s_axi_awaddr,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    // axi4-lite read
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [8:0]            s_axi_araddr,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    // measurement loop and factory trim
    input  wire acc_pkg::acc_meas_t    meas,
    input  wire acc_pkg::acc_cc_t      cc,
    input  wire acc_pkg::acc_trim_t    factory_trim,
    // threshold comparator
    input  wire logic                  cell_cmp_above,
    output logic                       cal_active,
    output logic [7:0]                 cal_coef,
    output logic [7:0]                 cell_overvoltage_threshold,
    output logic [7:0]                 cell_undervoltage_threshold
);
    acc_pkg::acc_state_t s;
    acc_pkg::acc_state_t n;
    logic [acc_pkg::NCH-1:0][15:0] gain_use;
    logic [acc_pkg::NCH-1:0][15:0] gain_rd;
    logic [31:0] cap_gain;
    logic        cal_req;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] sat16(input logic [33:0] v);
        sat16 = (&v[33:15] || ~|v[33:15]) ? v[15:0] : {v[33], {15{~v[33]}}};
    endfunction

    function automatic logic [31:0] sat32(input logic [63:0] v);
        sat32 = (&v[63:31] || ~|v[63:31]) ? v[31:0] : {v[63], {31{~v[63]}}};
    endfunction

    // trim subtracted in counts, gain in 1/65536 steps, then offset
    function automatic logic [15:0] correct_volt(input logic [31:0] raw, input logic [15:0] trim,
                                                 input logic [15:0] gain, input logic [15:0] off);
        logic signed [33:0] c;
        logic        [15:0] cnt;
        logic signed [33:0] p;
        c   = $signed({raw[31], raw[31], raw}) - $signed({{18{trim[15]}}, trim});
        cnt = sat16(c);
        p   = $signed({18'h0_0000, gain}) * $signed({{18{cnt[15]}}, cnt});
        p   = (p >>> 16) - $signed({{18{off[15]}}, off});
        correct_volt = sat16(p);
    endfunction

    // count difference times a single precision gain, to an integer
    function automatic logic [31:0] scale_cc(input logic [31:0] d, input logic [31:0] g);
        logic signed [63:0] p;
        logic signed [63:0] r;
        logic        [7:0]  e;
        e = g[30:23];
        p = $signed({{32{d[31]}}, d}) * $signed({40'h00_0000_0000, |e, g[22:0]});
        if (g[31])
            p = -p;
        if (e == 8'h00 || p == 64'sh0)
            r = 64'sh0;
        else if (e >= acc_pkg::FLT_SHL_MAX)
            r = p[63] ? {1'b1, 63'h0} : {1'b0, {63{1'b1}}};
        else if (e >= acc_pkg::FLT_POINT)
            r = p <<< (e - acc_pkg::FLT_POINT);
        else
            r = p >>> (acc_pkg::FLT_POINT - e);
        scale_cc = sat32(r);
    endfunction

    // truncating float product; denormals flush to zero
    function automatic logic [31:0] fmul(input logic [31:0] a, input logic [31:0] b);
        logic [47:0] m;
        logic [9:0]  e;
        m = {1'b1, a[22:0]} * {1'b1, b[22:0]};
        e = {2'b00, a[30:23]} + {2'b00, b[30:23]} - 10'h07f + {9'h000, m[47]};
        if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e[9])
            fmul = 32'h0000_0000;
        else if (e[8] || e[7:0] == 8'hff)
            fmul = {a[31] ^ b[31], 8'hff, 23'h00_0000};
        else
            fmul = {a[31] ^ b[31], e[7:0], m[47] ? m[46:24] : m[45:23]};
    endfunction

    // {hit, index} of a 20-word window
    function automatic logic [5:0] win(input logic [8:0] a, input logic [8:0] base);
        logic [8:0] d;
        d   = a - base;
        win = {(a >= base) && (d[8:2] < 7'(acc_pkg::NCH)), d[6:2]};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        for (int b = 0; b < 4; b++)
            if (st[b])
                old[8*b +: 8] = d[8*b +: 8];
        merge = old;
    endfunction

    // ****************************************
    // gain selection and readback
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < acc_pkg::NCH; gi++)
        begin : g_gain
            localparam logic [15:0] DEF = (gi == acc_pkg::CH_ADC) ? acc_pkg::GAIN_ADC_DEF
                                                                   : acc_pkg::GAIN_CELL_DEF; // [R09]
            assign gain_use[gi] = s.gain_set[gi] ? s.gain_wr[gi]                              // [R01] [R04]
                                : (factory_trim.gain[gi] != 16'h0000 ? factory_trim.gain[gi] : DEF); // [R03]
            assign gain_rd[gi]  = s.cfg_update ? (s.gain_set[gi] ? s.gain_wr[gi] : 16'h0000)  // [R07]
                                : (!s.gain_set[gi] && s.full_access) ? factory_trim.gain[gi]  // [R06]
                                : gain_use[gi];                                              // [R08]
        end
    endgenerate

    assign cap_gain = fmul(s.current_conversion_gain, acc_pkg::CAP_FACTOR); // [R19] [R20]
    assign cal_req  = s.aw_got && s.w_got && !s.bvalid && s.awaddr == acc_pkg::ADDR_CTRL
                    && s.wstrb[0] && (s.wdata[acc_pkg::CTRL_OV_CAL] || s.wdata[acc_pkg::CTRL_UV_CAL]);

    assign s_axi_awready = !s.aw_got && !s.bvalid;
    assign s_axi_wready  = !s.w_got && !s.bvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;
    assign cal_active    = s.cal_st != acc_pkg::CAL_IDLE;
    assign cal_coef      = s.coef;
    assign cell_overvoltage_threshold  = s.ov_thr;
    assign cell_undervoltage_threshold = s.uv_thr;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [5:0]  w;
        logic [31:0] rd;
        logic [15:0] off;
        logic [31:0] quot;
        n    = s;
        w    = 6'h00;
        rd   = 32'h0000_0000;
        off  = 16'h0000;
        quot = 32'h0000_0000;

        // write channel: address and data in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready)
            n.bvalid = 1'b0;
        if (s.aw_got && s.w_got && !s.bvalid)
        begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = acc_pkg::RESP_OKAY;
            w        = win(s.awaddr, acc_pkg::ADDR_GAIN);
            case (s.awaddr)
                acc_pkg::ADDR_CTRL:
                begin
                    if (s.wstrb[0])
                    begin
                        n.cfg_update  = s.wdata[acc_pkg::CTRL_CFG];
                        n.full_access = s.wdata[acc_pkg::CTRL_FULL];
                    end
                end
                acc_pkg::ADDR_VCELL:    n.vcell_off = 16'(merge({16'h0000, s.vcell_off}, s.wdata,
                                                          s.wstrb)); // [R02]
                acc_pkg::ADDR_VDIV:     n.vdiv_off  = 16'(merge({16'h0000, s.vdiv_off}, s.wdata, s.wstrb));
                acc_pkg::ADDR_CC_OFF:   n.cc_off    = 16'(merge({16'h0000, s.cc_off}, s.wdata, s.wstrb));
                acc_pkg::ADDR_CC_SAMP:  n.cc_samp   = 8'(merge({24'h00_0000, s.cc_samp}, s.wdata, s.wstrb));
                acc_pkg::ADDR_CURRENT_CONVERSION_GAIN:  n.current_conversion_gain   = merge(s.current_conversion_gain, s.wdata, s.wstrb); // [R20]
                acc_pkg::ADDR_OV_OVR:   n.ov_ovr    = 8'(merge({24'h00_0000, s.ov_ovr}, s.wdata, s.wstrb));
                acc_pkg::ADDR_UV_OVR:   n.uv_ovr    = 8'(merge({24'h00_0000, s.uv_ovr}, s.wdata, s.wstrb));
                default:
                begin
                    if (w[5])
                    begin
                        n.gain_wr[w[4:0]]  = 16'(merge({16'h0000, s.gain_wr[w[4:0]]}, s.wdata, s.wstrb));
                        n.gain_set[w[4:0]] = 1'b1; // [R04]
                    end
                    else
                        n.bresp = acc_pkg::RESP_SLVERR;
                end
            endcase
        end

        // read channel, answered on the edge that takes the address
        if (s.rvalid && s_axi_rready)
            n.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            n.rvalid = 1'b1;
            n.rresp  = acc_pkg::RESP_OKAY;
            case (s_axi_araddr)
                acc_pkg::ADDR_CTRL:     rd = {30'h0000_0000, s.full_access, s.cfg_update};
                acc_pkg::ADDR_STAT:     rd = {16'h0000, s.cal_res, 7'h00, cal_active};
                acc_pkg::ADDR_VCELL:    rd = {16'h0000, s.vcell_off};
                acc_pkg::ADDR_VDIV:     rd = {16'h0000, s.vdiv_off};
                acc_pkg::ADDR_CC_OFF:   rd = {16'h0000, s.cc_off};
                acc_pkg::ADDR_CC_SAMP:  rd = {24'h00_0000, s.cc_samp};
                acc_pkg::ADDR_CURRENT_CONVERSION_GAIN:  rd = s.current_conversion_gain;
                acc_pkg::ADDR_CAP_GAIN: rd = cap_gain;
                acc_pkg::ADDR_OV_OVR:   rd = {24'h00_0000, s.ov_ovr};
                acc_pkg::ADDR_UV_OVR:   rd = {24'h00_0000, s.uv_ovr};
                acc_pkg::ADDR_THR:      rd = {16'h0000, s.uv_thr, s.ov_thr};
                acc_pkg::ADDR_CURRENT:  rd = s.current;
                default:
                begin
                    w = win(s_axi_araddr, acc_pkg::ADDR_GAIN);
                    if (w[5])
                        rd = {16'h0000, gain_rd[w[4:0]]};
                    else
                    begin
                        w = win(s_axi_araddr, acc_pkg::ADDR_RES);
                        if (w[5])
                            rd = {{16{s.vres[w[4:0]][15]}}, s.vres[w[4:0]]};
                        else
                            n.rresp = acc_pkg::RESP_SLVERR;
                    end
                end
            endcase
            n.rdata = rd;
        end

        // voltage correction; cells and adc input in mV, dividers in user units
        if (meas.valid && meas.chan < 5'(acc_pkg::NCH))
        begin
            if (meas.chan < 5'(acc_pkg::NCELL))
                off = s.vcell_off;                // [R10] [R13]
            else if (meas.chan != acc_pkg::CH_ADC)
                off = s.vdiv_off;                 // [R11]
            n.vres[meas.chan] = correct_volt(meas.raw, factory_trim.adc_offset,
                                             gain_use[meas.chan], off); // [R05] [R12] [R22]
        end

        // current: a zero sample count leaves the offset out
        if (cc.valid)
        begin
            if (s.cc_samp != 8'h00)
                quot = 32'($signed({{16{s.cc_off[15]}}, s.cc_off}) / $signed({24'h00_0000, s.cc_samp}));
            n.current = scale_cc(cc.raw - quot, s.current_conversion_gain); // [R18] [R22]
        end

        n.ov_thr = (s.ov_ovr != 8'h00) ? s.ov_ovr : factory_trim.ov; // [R17]
        n.uv_thr = (s.uv_ovr != 8'h00) ? s.uv_ovr : factory_trim.uv; // [R17]

        // successive approximation on the top cell comparator
        unique case (s.cal_st)
            acc_pkg::CAL_IDLE:
            begin
                if (cal_req && s.cfg_update) // [R14]
                begin
                    n.cal_st  = acc_pkg::CAL_SETTLE;
                    n.cal_uv  = !s.wdata[acc_pkg::CTRL_OV_CAL];
                    n.cal_bit = 3'h7;
                    n.coef    = 8'h80;
                    n.settle  = 16'h0000;
                end
            end
            acc_pkg::CAL_SETTLE:
            begin
                if (s.settle == 16'(acc_pkg::CAL_SETTLE_CYC - 1))
                    n.cal_st = acc_pkg::CAL_DECIDE;
                else
                    n.settle = s.settle + 16'h0001;
            end
            acc_pkg::CAL_DECIDE:
            begin
                // above the applied level the threshold is too high: drop the bit
                if (!cell_cmp_above)
                    n.coef[s.cal_bit] = 1'b0;
                if (s.cal_bit == 3'h0)
                    n.cal_st = acc_pkg::CAL_DONE;
                else
                begin
                    n.cal_bit                   = s.cal_bit - 3'h1;
                    n.coef[s.cal_bit - 3'h1]    = 1'b1;
                    n.settle                    = 16'h0000;
                    n.cal_st                    = acc_pkg::CAL_SETTLE;
                end
            end
            acc_pkg::CAL_DONE:
            begin
                n.cal_res = s.coef;
                n.cal_st  = acc_pkg::CAL_IDLE;
                if (s.cal_uv)
                    n.uv_ovr = s.coef; // [R16]
                else
                    n.ov_ovr = s.coef; // [R15]
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s         <= '0;
            s.cc_samp <= acc_pkg::CC_SAMP_RST;
            s.current_conversion_gain <= acc_pkg::CURRENT_CONVERSION_GAIN_RST;
        end
        else
            s <= n;
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before bready");
    a_general_analog_input_no_off: assert property (meas.valid && meas.chan == acc_pkg::CH_ADC // [R12]
        && meas.raw == {{16{factory_trim.adc_offset[15]}}, factory_trim.adc_offset}
        |=> s.vres[acc_pkg::CH_ADC] == 16'h0000)
        else $error("adc input result carries an offset");
    a_cell_offset: assert property (meas.valid && meas.chan == 5'h00 && s.vcell_off != 16'h8000 // [R10]
        && meas.raw == {{16{factory_trim.adc_offset[15]}}, factory_trim.adc_offset}
        |=> s.vres[0] == 16'(-$past(s.vcell_off)))
        else $error("cell result does not subtract the cell offset");
    a_cal_store_ov: assert property (s.cal_st == acc_pkg::CAL_DONE && !s.cal_uv // [R15]
        |=> s.ov_ovr == $past(s.coef) && s.cal_res == $past(s.coef) && !cal_active)
        else $error("overvoltage coefficient not stored");
    a_cal_store_uv: assert property (s.cal_st == acc_pkg::CAL_DONE && s.cal_uv // [R16]
        |=> s.uv_ovr == $past(s.coef) && s.cal_res == $past(s.coef))
        else $error("undervoltage coefficient not stored");
    a_cal_refused: assert property (cal_req && !s.cfg_update && !cal_active |=> !cal_active) // [R14]
        else $error("search started outside config mode");
    a_ov_override: assert property (s.ov_ovr == 8'h00 ##1 s.ov_ovr == 8'h00 // [R17]
        |-> cell_overvoltage_threshold == $past(factory_trim.ov))
        else $error("zero override did not select the trim threshold");
    a_cfg_readback: assert property (s_axi_arvalid && s_axi_arready && s.cfg_update && !s.gain_set[1] // [R07]
        && s_axi_araddr == acc_pkg::ADDR_GAIN + 9'h004 |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
        else $error("unwritten gain not zero in config mode");
    a_cap_gain: assert property (s.current_conversion_gain == acc_pkg::CURRENT_CONVERSION_GAIN_RST |-> cap_gain == acc_pkg::CAP_FACTOR) // [R19]
        else $error("capacity gain is not the scaled current gain");
    a_default_gain: assert property (!s.gain_set[0] && factory_trim.gain[0] == 16'h0000 // [R03]
        |-> gain_use[0] == acc_pkg::GAIN_CELL_DEF)
        else $error("default cell gain not used");
endmodule
`default_nettype wire

//--- core/acc_pkg.sv
// package: register map, constants and carrier types of the adc calibration block
`default_nettype none
package acc_pkg;
    localparam int NCH    = 20;
    localparam int NCELL  = 16;
    localparam int COEF_W = 8;
    localparam int ADDR_W = 9;

    // channel numbers after the sixteen cells
    localparam logic [4:0] CH_TOS  = 5'h10;
    localparam logic [4:0] CH_PACK = 5'h11;
    localparam logic [4:0] CH_LD   = 5'h12;
    localparam logic [4:0] CH_ADC  = 5'h13;

    localparam logic [15:0] GAIN_CELL_DEF = 16'h2f58;
    localparam logic [15:0] GAIN_ADC_DEF  = 16'h0fc8;
    // single precision 298261.6178
    localparam logic [31:0] CAP_FACTOR    = 32'h4891_a2b4;
    localparam logic [7:0]  FLT_POINT     = 8'h96;
    localparam logic [7:0]  FLT_SHL_MAX   = 8'h9e;

    // search settling time per coefficient bit
    localparam int CLK_NS         = 20;
    localparam int CAL_SETTLE_NS  = 2000;
    localparam int CAL_SETTLE_CYC = (CAL_SETTLE_NS + CLK_NS - 1) / CLK_NS;

    // byte addresses
    localparam logic [8:0] ADDR_CTRL     = 9'h000;
    localparam logic [8:0] ADDR_STAT     = 9'h004;
    localparam logic [8:0] ADDR_VCELL    = 9'h008;
    localparam logic [8:0] ADDR_VDIV     = 9'h00c;
    localparam logic [8:0] ADDR_CC_OFF   = 9'h010;
    localparam logic [8:0] ADDR_CC_SAMP  = 9'h014;
    localparam logic [8:0] ADDR_CURRENT_CONVERSION_GAIN  = 9'h018;
    localparam logic [8:0] ADDR_CAP_GAIN = 9'h01c;
    localparam logic [8:0] ADDR_OV_OVR   = 9'h020;
    localparam logic [8:0] ADDR_UV_OVR   = 9'h024;
    localparam logic [8:0] ADDR_THR      = 9'h028;
    localparam logic [8:0] ADDR_CURRENT  = 9'h02c;
    localparam logic [8:0] ADDR_GAIN     = 9'h040;
    localparam logic [8:0] ADDR_RES      = 9'h100;

    localparam int CTRL_CFG    = 0;
    localparam int CTRL_FULL   = 1;
    localparam int CTRL_OV_CAL = 2;
    localparam int CTRL_UV_CAL = 3;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [7:0]  CC_SAMP_RST = 8'h01;
    localparam logic [31:0] CURRENT_CONVERSION_GAIN_RST = 32'h3f80_0000;

    typedef enum logic [1:0] {
        CAL_IDLE   = 2'b00,
        CAL_SETTLE = 2'b01,
        CAL_DECIDE = 2'b11,
        CAL_DONE   = 2'b10
    } acc_cal_t;

    typedef struct packed {
        logic        valid;
        logic [4:0]  chan;
        logic [31:0] raw;
    } acc_meas_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] raw;
    } acc_cc_t;

    typedef struct packed {
        logic [NCH-1:0][15:0] gain;
        logic [15:0]          adc_offset;
        logic [COEF_W-1:0]    ov;
        logic [COEF_W-1:0]    uv;
    } acc_trim_t;

    typedef struct packed {
        logic                 aw_got;
        logic                 w_got;
        logic [8:0]           awaddr;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
        logic                 cfg_update;
        logic                 full_access;
        logic [15:0]          vcell_off;
        logic [15:0]          vdiv_off;
        logic [15:0]          cc_off;
        logic [7:0]           cc_samp;
        logic [31:0]          current_conversion_gain;
        logic [COEF_W-1:0]    ov_ovr;
        logic [COEF_W-1:0]    uv_ovr;
        logic [COEF_W-1:0]    ov_thr;
        logic [COEF_W-1:0]    uv_thr;
        logic [NCH-1:0][15:0] gain_wr;
        logic [NCH-1:0]       gain_set;
        logic [NCH-1:0][15:0] vres;
        logic [31:0]          current;
        acc_cal_t             cal_st;
        logic                 cal_uv;
        logic [2:0]           cal_bit;
        logic [COEF_W-1:0]    coef;
        logic [COEF_W-1:0]    cal_res;
        logic [15:0]          settle;
    } acc_state_t;
endpackage
`default_nettype wire

//--- tb/acc_cmp_model.sv
// comparator model standing in for the applied top cell voltage
`timescale 1ns/1ns
`default_nettype none
module acc_cmp_model (
    // trial coefficient and applied level
    input  wire logic [7:0] cal_coef,
    input  wire logic [7:0] target,
    // comparator answer
    output logic            cell_cmp_above
);
    // applied level is held steady for the whole search
    assign cell_cmp_above = target >= cal_coef;
endmodule
`default_nettype wire

//--- tb/tb_adc_calibration_correction.sv
// self-checking bench of the adc calibration block
`timescale 1ns/1ns
`default_nettype none
module tb_adc_calibration_correction;
    logic               mclk, reset_n, aw, w, bready, ar, rready, above, act;
    logic               awrdy, wrdy, bv, arrdy, rv;
    logic [8:0]         awa, ara;
    logic [31:0]        wd, rd;
    logic [1:0]         br, rr;
    logic [7:0]         tgt, coef, ovt, uvt;
    acc_pkg::acc_meas_t meas;
    acc_pkg::acc_cc_t   cc;
    acc_pkg::acc_trim_t trim;
    int                 mismatches = 0;
    int                 comparisons = 0;
    acc_adc_cal acc_adc_cal_i (.mclk(mclk), .reset_n(reset_n), .s_axi_awvalid(aw), .s_axi_awready(awrdy),
        .s_axi_awaddr(awa), .s_axi_wvalid(w), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_bresp(br), .s_axi_arvalid(ar), .s_axi_arready(arrdy),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rready), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .meas(meas), .cc(cc), .factory_trim(trim), .cell_cmp_above(above), .cal_active(act), .cal_coef(coef),
        .cell_overvoltage_threshold(ovt), .cell_undervoltage_threshold(uvt));
    acc_cmp_model acc_cmp_model_i (.cal_coef(coef), .target(tgt), .cell_cmp_above(above));
    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    // handshakes judged at the negedge before the edge that takes them
    task automatic wr(input logic [8:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge mclk);
        {aw, w, bready, awa, wd} <= {3'b111, a, d};
        do
        begin
            @(negedge mclk);
            {ta, tw, tb, r} = {aw & awrdy, w & wrdy, bv, br};
            @(posedge mclk);
            {aw, w} <= {aw & !ta, w & !tw};
        end
        while (!tb);
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge mclk);
        {ar, rready, ara} <= {2'b11, a};
        do
        begin
            @(negedge mclk);
            {ta, tr, d, r} = {ar & arrdy, rv, rd, rr};
            @(posedge mclk);
            ar <= ar & !ta;
        end
        while (!tr);
        rready <= 1'b0;
    endtask
    task automatic wo(input logic [8:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask
    task automatic rc(input string n, input logic [8:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rdr(a, d, r);
        chk(n, e, d);
    endtask
    task automatic ms(input logic [4:0] c, input logic [31:0] raw, input logic [31:0] e);
        @(posedge mclk);
        meas <= '{1'b1, c, raw};
        @(posedge mclk);
        meas.valid <= 1'b0;
        rc("result", acc_pkg::ADDR_RES + {c, 2'b00}, e);
    endtask
    task automatic t_misc;
        logic [31:0] d;
        logic [1:0]  r;
        rc("current_conversion_gain", acc_pkg::ADDR_CURRENT_CONVERSION_GAIN, acc_pkg::CURRENT_CONVERSION_GAIN_RST);
        chk("ov thr", 8'h33, ovt);
        rc("cap gain", acc_pkg::ADDR_CAP_GAIN, acc_pkg::CAP_FACTOR);
        wo(acc_pkg::ADDR_CC_OFF, 32'h0000_00c8);
        wo(acc_pkg::ADDR_CC_SAMP, 32'h0000_0002);
        wo(acc_pkg::ADDR_CURRENT_CONVERSION_GAIN, 32'h40ef_41f2);
        @(posedge mclk);
        cc <= '{1'b1, 32'hffff_ff9c};
        @(posedge mclk);
        cc.valid <= 1'b0;
        rc("current", acc_pkg::ADDR_CURRENT, 32'hffff_fa28);
        rdr(9'h0f0, d, r);
        chk("rresp", acc_pkg::RESP_SLVERR, r);
        wr(acc_pkg::ADDR_THR, 32'h0000_0001, r);
        chk("bresp", acc_pkg::RESP_SLVERR, r);
        $display("misc done");
    endtask
    task automatic t_meas;
        wo(acc_pkg::ADDR_VCELL, 32'h0000_000a);
        wo(acc_pkg::ADDR_VDIV, 32'h0000_0005);
        ms(5'h00, 32'h0000_0010, -10);
        ms(acc_pkg::CH_ADC, 32'h0000_0010, 0);
        ms(5'h00, 32'h0000_4010, 12120 * 16384 / 65536 - 10);
        ms(acc_pkg::CH_TOS, 32'h0000_4010, 4096 * 16384 / 65536 - 5);
        ms(acc_pkg::CH_ADC, 32'h0000_4010, 4040 * 16384 / 65536);
        ms(acc_pkg::CH_ADC, 32'h8000_0010, -4040 * 32768 / 65536);
        wo(acc_pkg::ADDR_GAIN, 32'h0000_2000);
        ms(5'h00, 32'h0000_4010, 8192 * 16384 / 65536 - 10);
        ms(5'h01, 32'h0000_4010, 12032 * 16384 / 65536 - 10);
        $display("meas done");
    endtask
    task automatic t_read;
        wo(acc_pkg::ADDR_CTRL, 32'h0000_0002);
        rc("trim gain", acc_pkg::ADDR_GAIN + 9'h004, 32'h0000_2f00);
        wo(acc_pkg::ADDR_CTRL, 32'h0000_0001);
        rc("cfg gain", acc_pkg::ADDR_GAIN + 9'h004, 32'h0000_0000);
        wo(acc_pkg::ADDR_GAIN + 9'h004, 32'h0000_3000);
        rc("cfg gain", acc_pkg::ADDR_GAIN + 9'h004, 32'h0000_3000);
        wo(acc_pkg::ADDR_CTRL, 32'h0000_0000);
        rc("used gain", acc_pkg::ADDR_GAIN, 32'h0000_2000);
        wo(acc_pkg::ADDR_CTRL, 32'h0000_0004);
        chk("refused", 0, act);
        $display("readback done");
    endtask
    task automatic t_cal(input logic uv, input logic [7:0] t);
        tgt <= t;
        wo(acc_pkg::ADDR_CTRL, 32'h0000_0001);
        wo(acc_pkg::ADDR_CTRL, {28'h0, uv, !uv, 2'b01});
        for (int i = 0; i < 1000 && act !== 1'b0; i++)
            @(negedge mclk);
        rc("coef", acc_pkg::ADDR_STAT, {16'h0, t, 8'h00});
        chk("thr", t, uv ? uvt : ovt);
        $display("search done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial
    begin
        #400000;
        mismatches++;
        conclude();
    end
    initial
    begin
        {reset_n, aw, w, bready, ar, rready, awa, wd, ara, meas, cc, tgt, trim} = '0;
        {trim.gain[1], trim.gain[16], trim.adc_offset, trim.ov} = {16'h2f00, 16'h1000, 16'h0010, 8'h33};
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_misc();
        t_meas();
        t_read();
        t_cal(1'b0, 8'h5a);
        t_cal(1'b1, 8'h27);
        conclude();
    end
endmodule
`default_nettype wire
